// [logic/pbs_sram_port.sv]
// synchronous pipelined common-io burst sram port with byte writes and sleep
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_sram_port
    import pbs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // command inputs, synchronous to clk_sys
    input wire logic clock_qualifier_n,
    input wire logic chip_select_1_n,
    input wire logic chip_select_2,
    input wire logic chip_select_3_n,
    input wire logic write_strobe_n,
    input wire logic burst_advance_load_n,
    input wire logic burst_order,
    input wire logic [`PBS_ADDR_W-1:0] addr,
    input wire logic [`PBS_LANES-1:0] byte_lane_strobe_n,
    // asynchronous controls
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // data lanes
    input wire logic [`PBS_DATA_W-1:0] data_lane_in,
    output logic [`PBS_DATA_W-1:0] data_lane_out,
    output logic data_lane_oe,
    // parity lanes
    input wire logic [`PBS_LANES-1:0] parity_lane_in,
    output logic [`PBS_LANES-1:0] parity_lane_out,
    output logic parity_lane_oe,
    // status
    output logic sleep_active
);

    ////////////////////////////////////////////////////////////////////////
    // burst address step

    function automatic logic [`PBS_BURST_W-1:0] burst_lo(
        input logic interleaved,
        input logic [`PBS_BURST_W-1:0] start,
        input logic [`PBS_BURST_W-1:0] count
    );
        if (interleaved) begin
            burst_lo = start ^ count;
        end else begin
            burst_lo = `PBS_BURST_W'(start + count);
        end
    endfunction

    // lanes drive only for a read result with output enable low
    function automatic logic lane_enable(
        input logic drive,
        input logic oe_n
    );
        lane_enable = drive && !oe_n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic sleep_s1_reg;
    logic sleep_s2_reg;
    logic sleep_s3_reg;
    logic sleep_level_reg;
    pbs_sleep_t sleep_state_reg;
    logic [`PBS_SLEEP_CNT_W-1:0] sleep_cnt_reg;

    logic burst_active_reg;
    logic burst_wr_reg;
    logic [`PBS_ADDR_W-1:0] burst_base_reg;
    logic [`PBS_BURST_W-1:0] burst_cnt_reg;

    logic s1_rd_reg;
    logic s1_wr_reg;
    logic [`PBS_ADDR_W-1:0] s1_addr_reg;
    logic [`PBS_LANES-1:0] s1_strobe_n_reg;
    logic s2_wr_reg;
    logic [`PBS_ADDR_W-1:0] s2_addr_reg;
    logic [`PBS_LANES-1:0] s2_strobe_n_reg;
    logic rd_drive_reg;

    logic awake;
    logic qual;
    logic selected;
    logic [`PBS_BURST_W-1:0] cnt_next;
    logic cmd_valid;
    logic cmd_wr;
    logic [`PBS_ADDR_W-1:0] cmd_addr;
    logic [`PBS_DATA_W-1:0] rd_data;
    logic [`PBS_LANES-1:0] rd_par;

    ////////////////////////////////////////////////////////////////////////
    // sleep request synchroniser and sleep sequencing

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sleep_s1_reg <= 1'b0;
            sleep_s2_reg <= 1'b0;
            sleep_s3_reg <= 1'b0;
            sleep_level_reg <= 1'b0;
        end else begin
            sleep_s1_reg <= sleep_request;
            sleep_s2_reg <= sleep_s1_reg;
            sleep_s3_reg <= sleep_s2_reg;
            if (sleep_s2_reg == sleep_s3_reg) begin
                sleep_level_reg <= sleep_s3_reg;
            end
        end
    end

    // sleep runs on every edge; the clock qualifier does not hold it off
    // commands that meet a sequencer that is not awake are lost, not queued
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sleep_state_reg <= PBS_AWAKE;
            sleep_cnt_reg <= '0;
        end else begin
            unique case (sleep_state_reg)
                PBS_AWAKE: begin
                    sleep_cnt_reg <= '0;
                    if (sleep_level_reg) begin
                        sleep_state_reg <= PBS_ENTER;
                    end
                end
                PBS_ENTER: begin
                    sleep_cnt_reg <= `PBS_SLEEP_CNT_W'(sleep_cnt_reg + 1'b1);
                    if (sleep_cnt_reg == `PBS_SLEEP_CNT_W'(`PBS_SLEEP_ENTRY_CYC - 1)) begin
                        sleep_state_reg <= PBS_ASLEEP;
                        sleep_cnt_reg <= '0;
                    end
                end
                PBS_ASLEEP: begin
                    if (!sleep_level_reg) begin
                        sleep_state_reg <= PBS_EXIT;
                    end
                end
                PBS_EXIT: begin
                    sleep_cnt_reg <= `PBS_SLEEP_CNT_W'(sleep_cnt_reg + 1'b1);
                    if (sleep_cnt_reg == `PBS_SLEEP_CNT_W'(`PBS_SLEEP_EXIT_CYC - 1)) begin
                        sleep_state_reg <= PBS_AWAKE;
                        sleep_cnt_reg <= '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sleep_active <= 1'b0;
        end else begin
            sleep_active <= (sleep_state_reg != PBS_AWAKE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode

    always_comb begin
        awake = (sleep_state_reg == PBS_AWAKE);
        qual = awake && !clock_qualifier_n;
        selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
        cnt_next = `PBS_BURST_W'(burst_cnt_reg + 1'b1);
        if (!burst_advance_load_n) begin
            cmd_valid = selected;
            cmd_wr = !write_strobe_n;
            cmd_addr = addr;
        end else begin
            // selects and write strobe are ignored on a burst beat
            cmd_valid = burst_active_reg;
            cmd_wr = burst_wr_reg;
            cmd_addr = {burst_base_reg[`PBS_ADDR_W-1:`PBS_BURST_W],
                        burst_lo(burst_order, burst_base_reg[`PBS_BURST_W-1:0], cnt_next)};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst counter

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            burst_active_reg <= 1'b0;
            burst_wr_reg <= 1'b0;
            burst_base_reg <= '0;
            burst_cnt_reg <= '0;
        end else if (!awake) begin
            burst_active_reg <= 1'b0;
        end else if (qual) begin
            if (!burst_advance_load_n) begin
                burst_active_reg <= selected;
                burst_wr_reg <= !write_strobe_n;
                burst_base_reg <= addr;
                burst_cnt_reg <= '0;
            end else begin
                // beats past the fourth wrap back to the start address
                burst_cnt_reg <= cnt_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command and write data pipeline

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_rd_reg <= 1'b0;
            s1_wr_reg <= 1'b0;
            s1_addr_reg <= '0;
            s1_strobe_n_reg <= '1;
            s2_wr_reg <= 1'b0;
            s2_addr_reg <= '0;
            s2_strobe_n_reg <= '1;
        end else if (!awake) begin
            s1_rd_reg <= 1'b0;
            s1_wr_reg <= 1'b0;
            s2_wr_reg <= 1'b0;
        end else if (qual) begin
            s1_rd_reg <= cmd_valid && !cmd_wr;
            s1_wr_reg <= cmd_valid && cmd_wr;
            s1_addr_reg <= cmd_addr;
            // the data phase uses strobes taken at the command edge, not live pins
            s1_strobe_n_reg <= byte_lane_strobe_n;
            s2_wr_reg <= s1_wr_reg;
            s2_addr_reg <= s1_addr_reg;
            s2_strobe_n_reg <= s1_strobe_n_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage, one array per byte lane
    // limitation: a read one command behind a write to the same word
    // returns the old word, since both land on the same edge

    genvar g;
    generate
        for (g = 0; g < `PBS_LANES; g = g + 1) begin : gen_lane
            logic [`PBS_LANE_W:0] mem [0:`PBS_DEPTH-1];

            // data and parity of a lane share one strobe
            always_ff @(posedge clk_sys) begin
                if (qual && s2_wr_reg && !s2_strobe_n_reg[g]) begin
                    mem[s2_addr_reg] <= {parity_lane_in[g],
                                         data_lane_in[g*`PBS_LANE_W +: `PBS_LANE_W]};
                end
            end

            assign rd_data[g*`PBS_LANE_W +: `PBS_LANE_W] = mem[s1_addr_reg][`PBS_LANE_W-1:0];
            assign rd_par[g] = mem[s1_addr_reg][`PBS_LANE_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read output register and lane drivers

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_drive_reg <= 1'b0;
            data_lane_out <= '0;
            parity_lane_out <= '0;
        end else if (!awake) begin
            rd_drive_reg <= 1'b0;
        end else if (qual) begin
            // a write in its data phase never drives the lanes
            rd_drive_reg <= s1_rd_reg;
            data_lane_out <= rd_data;
            parity_lane_out <= rd_par;
        end
    end

    // enable gated without a clock so the lanes release at once
    // not flops on purpose: a sampled enable would lag the pin by a cycle
    assign data_lane_oe = lane_enable(rd_drive_reg, output_enable_n);
    assign parity_lane_oe = lane_enable(rd_drive_reg, output_enable_n);

endmodule

`default_nettype wire

// [logic/pbs_defines.svh]
// constants for the pipelined burst sram port
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// geometry: four byte lanes of eight data bits plus one parity bit
`define PBS_ADDR_W 21
`define PBS_DEPTH 2097152
`define PBS_LANES 4
`define PBS_LANE_W 8
`define PBS_DATA_W 32
`define PBS_BURST_W 2

// clock and sleep timing
`define PBS_CLK_PERIOD_NS 10
`define PBS_SLEEP_ENTRY_NS (2 * `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_EXIT_NS (2 * `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_ENTRY_CYC ((`PBS_SLEEP_ENTRY_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_EXIT_CYC ((`PBS_SLEEP_EXIT_NS + `PBS_CLK_PERIOD_NS - 1) / `PBS_CLK_PERIOD_NS)
`define PBS_SLEEP_CNT_W 2

`endif

// [logic/pbs_pkg.sv]
// types shared by the pipelined burst sram port
`default_nettype none
package pbs_pkg;

    typedef enum logic [3:0] {
        PBS_AWAKE = 4'h1,
        PBS_ENTER = 4'h2,
        PBS_ASLEEP = 4'h4,
        PBS_EXIT = 4'h8
    } pbs_sleep_t;

endpackage

`default_nettype wire

// [test/pbs_sram_port_props.sv]
// port assertions for the burst sram port
`timescale 1ns/100ps
`default_nettype none
`include "pbs_defines.svh"
module pbs_sram_port_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // commands
    input wire logic clock_qualifier_n,
    input wire logic write_strobe_n,
    input wire logic burst_advance_load_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    // lanes and status
    input wire logic [`PBS_DATA_W-1:0] data_lane_out,
    input wire logic data_lane_oe,
    input wire logic parity_lane_oe,
    input wire logic sleep_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic go;
    // sleep sync is slow, so any pending sleep excludes the load
    assign go = !clock_qualifier_n && !burst_advance_load_n && !sleep_request && !sleep_active;
    ////////////////////////////////////////
    a_write_tristate:
        assert property (go && !write_strobe_n ##1 !clock_qualifier_n |=> !data_lane_oe)
        else $error("lanes driven after write");
    a_oe_masked:
        assert property (output_enable_n |-> !data_lane_oe) else $error("lanes driven, oe high");
    a_parity_paired:
        assert property (data_lane_oe == parity_lane_oe) else $error("parity drive differs");
    a_stall_holds:
        assert property (clock_qualifier_n && !sleep_request && !sleep_active
            |=> $stable(data_lane_out)) else $error("output moved on stall");
    a_sleep_enter:
        assert property ($rose(sleep_request) ##2 sleep_request [*7] |-> sleep_active)
        else $error("sleep not entered");
    a_sleep_exit:
        assert property ($fell(sleep_request) ##2 !sleep_request [*8] |-> !sleep_active)
        else $error("sleep not left");
    a_sleep_quiet:
        assert property (sleep_active |-> !data_lane_oe) else $error("lanes driven asleep");
    a_reset_idle:
        assert property (disable iff (1'b0) !rst_n |=> !data_lane_oe && !sleep_active)
        else $error("not idle after reset");
    c_write: cover property (go && !write_strobe_n);
    c_read: cover property (data_lane_oe);
    c_sleep: cover property ($rose(sleep_active));
endmodule
bind pbs_sram_port pbs_sram_port_props prop_u (.clk_sys, .rst_n, .clock_qualifier_n,
    .write_strobe_n, .burst_advance_load_n, .output_enable_n, .sleep_request,
    .data_lane_out, .data_lane_oe, .parity_lane_oe, .sleep_active);
`default_nettype wire

// [test/pbs_ctl_model.sv]
// controller model driving the command side of the burst sram port
`timescale 1ns/100ps
`default_nettype none
module pbs_ctl_model (
    // clock and device drive
    input wire logic clk_sys,
    input wire logic [35:0] rd,
    input wire logic roe,
    // command and lane outputs
    output logic cqn,
    output logic wen,
    output logic adv,
    output logic oen,
    output logic [2:0] cs,
    output logic [20:0] a,
    output logic [3:0] ben,
    output logic [35:0] wd
);
    logic bwr = 0, dv = 0, nv = 0, mv = 0;
    logic [35:0] dq = '0, nq = '0, mq = '0;
    initial {cqn, wen, adv, oen, cs, a, ben} = '1;
    // released lanes show the inverse of the last value, never a stale copy
    assign wd = roe ? rd : dv ? dq : ~dq;
    task automatic op(logic ld, s, w, logic [20:0] ad, logic [3:0] b, logic [35:0] d,
                      logic st, o);
        {cqn, adv, wen, a, ben, oen} = {st, !ld, !w, ad, b, o};
        cs = s ? 3'b010 : 3'b010 ^ 3'(1 << $urandom_range(2));
        if (!st) begin
            // write data trails its command by two counted edges
            dv = mv;
            dq = mv ? mq : dq;
            mv = nv;
            mq = nq;
            if (ld) bwr = s && w;
            nv = bwr;
            nq = d;
        end
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [test/pbs_sram_port_test.sv]
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`default_nettype none
module pbs_sram_port_test;
    logic clk_sys = 0, rst_n = 0, sleep_request = 0, burst_order = 0;
    logic cqn, wen, adv, oen, doe, poe, slp, b_rd = 0, b_wr = 0, ec = 0, en = 0;
    logic [2:0] cs;
    logic [20:0] a, base;
    logic [3:0] ben, pout;
    logic [31:0] dout;
    logic [35:0] wd, eq, nq;
    logic [35:0] mem [logic [20:0]];
    int n_errors = 0, cmp_count = 0, cyc = 0, n;
    always #5 clk_sys = ~clk_sys;
    pbs_ctl_model ctl_u (.clk_sys, .rd({pout, dout}), .roe(doe), .cqn, .wen, .adv, .oen,
        .cs, .a, .ben, .wd);
    pbs_sram_port dut_u (.clk_sys, .rst_n, .clock_qualifier_n(cqn),
        .chip_select_1_n(cs[0]), .chip_select_2(cs[1]), .chip_select_3_n(cs[2]),
        .write_strobe_n(wen), .burst_advance_load_n(adv), .burst_order, .addr(a),
        .byte_lane_strobe_n(ben), .output_enable_n(oen), .sleep_request,
        .data_lane_in(wd[31:0]), .data_lane_out(dout), .data_lane_oe(doe),
        .parity_lane_in(wd[35:32]), .parity_lane_out(pout), .parity_lane_oe(poe),
        .sleep_active(slp));
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cb(string s, logic e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %b got %b", s, e, g);
        end
    endtask
    task automatic cw(string s, logic [35:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    function automatic logic [20:0] ba(int k);
        return {base[20:2], burst_order ? base[1:0] ^ 2'(k) : base[1:0] + 2'(k)};
    endfunction
    // one command, sometimes preceded by a stalled copy; results lag one edge
    task automatic step(logic ld, s, w, logic [3:0] b, logic o, int k);
        logic [20:0] ad;
        logic [35:0] d;
        ad = ba(k);
        d = {4'($urandom), $urandom};
        for (int t = int'($urandom_range(5) == 0); t >= 0; t--) begin
            ctl_u.op(ld, s, w, ad, b, d, t[0], o);
            if (t == 0) begin
                ec = en;
                eq = nq;
                if (ld) {b_rd, b_wr} = {s && !w, s && w};
                en = b_rd;
                nq = en ? mem[ad] : 'x;
                for (int g = 0; g < 4; g++) if (b_wr && !b[g]) begin
                    mem[ad][8*g+:8] = d[8*g+:8];
                    mem[ad][32+g] = d[32+g];
                end
            end
            cb("lane drive", ec && !o, doe);
            cb("parity drive", ec && !o, poe);
            if (ec && !o) cw("read data", eq, {pout, dout});
        end
    endtask
    initial begin
        void'($urandom(32'hC7B27D86));
        repeat (10) @(negedge clk_sys);
        rst_n = 1;
        for (int i = 0; i < 40; i++) begin
            base = i < 2 ? 21'h1 : 21'($urandom);
            burst_order = i < 2 ? i[0] : 1'($urandom);
            for (int k = 0; k < 4; k++) step(k == 0, k == 0, k == 0, 4'h0, 1'($urandom), k);
            n = $urandom_range(4, 1);
            for (int k = 0; k < n; k++)
                step(k == 0, k == 0, k == 0, 4'($urandom), 1'($urandom), k);
            repeat (2) step(1, 0, 1'($urandom), 4'hF, 1'($urandom), 0);
            if (i == 3) begin
                sleep_request = 1;
                repeat (10) step(1, 0, 0, 4'hF, 1, 0);
                cb("sleep entered", 1, slp);
                sleep_request = 0;
                repeat (10) step(1, 0, 0, 4'hF, 1, 0);
                cb("sleep left", 0, slp);
            end
            for (int k = 0; k < 4; k++) step(1, 1, 0, 4'hF, 1'($urandom), k);
            for (int k = 0; k < 4; k++) step(k == 0, k == 0, k != 0, 4'hF, 1'($urandom), k);
            $display("test %0d done, %0d mismatches", i, n_errors);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
